/* logic/abk_answerback.sv */
// Answerback message sequencer, top level
// Functional notes
// - Store holds 21 five-unit code positions
// - Position one always letters shift, twenty free
// - Received figures shift outside a keyboard cycle clears noncontention flag
// - Figures then D starts sequence if flag clear
// - Line trigger locks keyboard when lock fitted
// - Trigger releases code latches, starts cycle on the next clock
// - Blocked element spacing, unblocked element marking
// - Each character cycle advances pointer by one
// - Cycles run back to back through 21 unless generator stalls
// - Stop at wrap, latch codes, block cycles
// - Idle store never affects keyboard codes
// - Keyboard stays locked until manual unlock
// - Manual identify key starts same sequence
// - Local keyboard cycle sets self-holding flag
`timescale 1ns/100ps
module abk_answerback
	import abk_pkg::*;
#(
	parameter int MSG_LEN = ABK_MSG_LEN
) (
	// Clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_reset,
	// Received characters from the typing unit
	input  wire logic [ABK_CODE_W-1:0] i_rx_code,
	input  wire logic                  i_rx_valid,
	// Local keyboard character cycle pulse
	input  wire logic                  i_kbd_cycle,
	// Operator pins
	input  wire logic                  i_manual_identify_key,
	input  wire logic                  i_manual_unlock,
	input  wire logic                  i_lock_fitted,
	// Message store configuration, blocked element mask
	input  wire logic                  i_msg_wr,
	input  wire logic [ABK_PTR_W-1:0]  i_msg_addr,
	input  wire logic [ABK_CODE_W-1:0] i_msg_mask,
	// Signal generator
	output logic      [ABK_CODE_W-1:0] o_tx_code,
	output logic                       o_tx_valid,
	input  wire logic                  i_tx_ready,
	// Status
	output logic                       o_busy,
	output logic                       o_latch_release,
	output logic                       o_kbd_enable,
	output logic                       o_kbd_locked,
	output logic                       o_noncontention
);
	// ==========================================================
	// State
	abk_state_t                state_reg;
	abk_state_t                state_next;
	logic [ABK_PTR_W-1:0]      ptr_reg;
	logic [ABK_PTR_W-1:0]      ptr_next;
	logic                      noncon_reg;
	logic                      figs_seen_reg;
	logic                      lock_reg;
	logic                      kbd_en_reg;
	logic [2:0]                pin_s1_reg;
	logic [2:0]                pin_s2_reg;
	logic [2:0]                pin_s3_reg;
	logic [ABK_CODE_W-1:0]     store_mask [MSG_LEN];

	abk_stream_if #(.W(ABK_CODE_W)) seq_s ();
	abk_stream_if #(.W(ABK_CODE_W)) gen_s ();

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			pin_s3_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {i_lock_fitted, i_manual_unlock,
				i_manual_identify_key};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	wire key_edge    = pin_s2_reg[0] & ~pin_s3_reg[0];
	wire unlock_edge = pin_s2_reg[1] & ~pin_s3_reg[1];
	wire lock_fit    = pin_s2_reg[2];

	// ==========================================================
	// Message store
	genvar gi;
	generate
		for (gi = 0; gi < MSG_LEN; gi++) begin : g_store
			if (gi == 0) begin : g_stop
				assign store_mask[gi] = ABK_MASK_RST;
			end else begin : g_blade
				logic [ABK_CODE_W-1:0] mask_reg;
				always_ff @(posedge i_ref_clk) begin
					if (i_reset) begin
						mask_reg <= ABK_MASK_RST;
					end else if (i_msg_wr
						&& i_msg_addr == ABK_PTR_W'(gi)) begin
						mask_reg <= i_msg_mask;
					end
				end
				assign store_mask[gi] = mask_reg;
			end
		end
	endgenerate

	// ==========================================================
	// Decode
	wire rx_figs    = i_rx_valid && i_rx_code == ABK_FIGS;
	wire rx_d       = i_rx_valid && i_rx_code == ABK_CHAR_D;
	wire line_trig  = rx_d && figs_seen_reg && !noncon_reg;
	wire idle       = state_reg == ABK_IDLE;
	wire trig       = idle && (line_trig || key_edge);
	wire running    = state_reg == ABK_RUN;
	wire char_cycle = running && seq_s.ready;
	wire at_last    = ptr_reg == ABK_PTR_W'(MSG_LEN - 1);

	assign seq_s.valid = running;
	assign seq_s.data  = ~store_mask[ptr_reg];

	// ==========================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		ptr_next   = ptr_reg;
		case (state_reg)
			ABK_IDLE: begin
				if (trig) begin
					state_next = ABK_RUN;
					ptr_next   = ABK_PTR_RST;
				end
			end
			ABK_RUN: begin
				if (char_cycle) begin
					if (at_last) begin
						state_next = ABK_IDLE;
						ptr_next   = ABK_PTR_RST;
					end else begin
						ptr_next = ptr_reg + 5'h01;
					end
				end
			end
			default: begin
				state_next = ABK_IDLE;
				ptr_next   = ABK_PTR_RST;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_reg <= ABK_IDLE;
			ptr_reg   <= ABK_PTR_RST;
		end else begin
			state_reg <= state_next;
			ptr_reg   <= ptr_next;
		end
	end

	// ==========================================================
	// Noncontention, figures memory, keyboard lock
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			noncon_reg    <= ABK_FLAG_RST;
			figs_seen_reg <= ABK_FLAG_RST;
			lock_reg      <= ABK_FLAG_RST;
			kbd_en_reg    <= 1'b1;
		end else begin
			if (i_kbd_cycle) begin
				noncon_reg <= 1'b1;
			end else if (rx_figs) begin
				noncon_reg <= 1'b0;
			end
			if (i_rx_valid) begin
				figs_seen_reg <= rx_figs;
			end
			if (idle && line_trig && lock_fit) begin
				lock_reg <= 1'b1;
			end else if (unlock_edge) begin
				lock_reg <= 1'b0;
			end
			kbd_en_reg <= state_next == ABK_IDLE
				&& !(lock_reg && !unlock_edge)
				&& !(idle && line_trig && lock_fit);
		end
	end

	// ==========================================================
	// Output buffer
	abk_skid_buf #(.W(ABK_CODE_W)) u_buf (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.in_s      (seq_s),
		.out_s     (gen_s)
	);

	assign gen_s.ready     = i_tx_ready;
	assign o_tx_code       = gen_s.data;
	assign o_tx_valid      = gen_s.valid;
	assign o_busy          = running;
	assign o_latch_release = running;
	assign o_kbd_enable    = kbd_en_reg;
	assign o_kbd_locked    = lock_reg;
	assign o_noncontention = noncon_reg;

	// ==========================================================
	// Checks
	sequence s_last_char;
		running && seq_s.ready && at_last;
	endsequence

	sequence s_parked;
		idle && ptr_reg == ABK_PTR_RST;
	endsequence

	AST_START: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		trig |=> running && ptr_reg == ABK_PTR_RST)
		else $error("Trigger did not start sequence");
	AST_FIRST_LTRS: assert property (@(posedge i_ref_clk)
		disable iff (i_reset)
		running && ptr_reg == ABK_PTR_RST |-> seq_s.data == ABK_LTRS)
		else $error("First character not letters shift");
	AST_FIGS_CLR: assert property (@(posedge i_ref_clk)
		disable iff (i_reset)
		rx_figs && !i_kbd_cycle |=> !noncon_reg)
		else $error("Figures shift did not clear flag");
	AST_KBD_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_kbd_cycle |=> noncon_reg [*1] ##0 noncon_reg)
		else $error("Keyboard cycle did not set flag");
	AST_NO_SELF: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		idle && noncon_reg && !key_edge |=> idle)
		else $error("Station answered its own call");
	AST_ADVANCE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		char_cycle && !at_last |=> ptr_reg == $past(ptr_reg) + 5'h01)
		else $error("Pointer did not advance by one");
	AST_STOP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		s_last_char |=> s_parked)
		else $error("Sequence did not park at wrap");
	AST_RUN_LEN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$rose(running) ##0 i_tx_ready [*4] |-> running [*4])
		else $error("Sequence paused early");
	AST_LOCK_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		idle && line_trig && lock_fit |=> lock_reg && !kbd_en_reg)
		else $error("Keyboard not locked on trigger");
	AST_LOCK_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		lock_reg && !unlock_edge |=> lock_reg)
		else $error("Keyboard unlocked without manual unlock");
endmodule

/* logic/abk_pkg.sv */
// Shared constants for the answerback message sequencer
package abk_pkg;
	// ==========================================================
	// Code and store layout
	localparam int          ABK_CODE_W   = 5;
	localparam int          ABK_MSG_LEN  = 21;
	localparam int          ABK_PTR_W    = 5;
	localparam logic [4:0]  ABK_PTR_RST  = 5'h00;
	localparam logic [4:0]  ABK_PTR_LAST = 5'h14;
	// ==========================================================
	// Five-unit combinations, bit set means marking element
	localparam logic [4:0]  ABK_LTRS     = 5'h1f;
	localparam logic [4:0]  ABK_FIGS     = 5'h1b;
	localparam logic [4:0]  ABK_CHAR_D   = 5'h09;
	// ==========================================================
	// Reset values
	localparam logic        ABK_FLAG_RST = 1'b0;
	localparam logic [4:0]  ABK_MASK_RST = 5'h00;
	// ==========================================================
	// Sequencer states
	typedef enum logic {
		ABK_IDLE,
		ABK_RUN
	} abk_state_t;
endpackage

/* logic/abk_stream_if.sv */
// Character stream carrier between sequencer and buffer
`timescale 1ns/100ps
interface abk_stream_if #(parameter int W = 5);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

/* logic/abk_skid_buf.sv */
// Two-entry buffer in front of the signal generator
`timescale 1ns/100ps
module abk_skid_buf #(
	parameter int W = 5
) (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset,
	// Streams
	abk_stream_if.snk in_s,
	abk_stream_if.src out_s
);
	logic [W-1:0] out_data_reg;
	logic         out_valid_reg;
	logic [W-1:0] sk_data_reg;
	logic         sk_valid_reg;
	wire          push = in_s.valid & ~sk_valid_reg;
	wire          pop  = out_valid_reg & out_s.ready;
	wire          head_free = ~out_valid_reg | pop;

	assign in_s.ready  = ~sk_valid_reg;
	assign out_s.valid = out_valid_reg;
	assign out_s.data  = out_data_reg;

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			out_valid_reg <= 1'b0;
			sk_valid_reg  <= 1'b0;
			out_data_reg  <= '0;
			sk_data_reg   <= '0;
		end else if (head_free) begin
			if (sk_valid_reg) begin
				out_data_reg <= sk_data_reg;
				sk_valid_reg <= 1'b0;
			end else begin
				out_data_reg  <= in_s.data;
				out_valid_reg <= push;
			end
		end else if (push) begin
			sk_data_reg  <= in_s.data;
			sk_valid_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	AST_NO_LOSS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		out_valid_reg && !out_s.ready |=> out_valid_reg
			&& out_data_reg == $past(out_data_reg))
		else $error("Held word changed while stalled");
endmodule

/* tb/abk_remote_model.sv */
// Remote signal generator sink that accepts and logs characters
`timescale 1ns/100ps
module abk_remote_model
	import abk_pkg::*;
(
	// Clock
	input  wire logic                  i_ref_clk,
	// Character stream from the sequencer, slow mode select
	input  wire logic [ABK_CODE_W-1:0] i_tx_code,
	input  wire logic                  i_tx_valid,
	input  wire logic                  i_slow,
	output logic                       o_tx_ready
);
	// ==========================================================
	// Received characters
	logic [ABK_CODE_W-1:0] rx_log [0:63];
	int                    rx_cnt = 0;
	logic [1:0]            phase = 2'h0;
	// Slow mode stalls three cycles out of four
	always @(negedge i_ref_clk) begin
		phase <= phase + 2'h1;
		o_tx_ready <= !i_slow || (phase == 2'h3);
	end
	// One character per accept
	always @(posedge i_ref_clk) begin
		if (i_tx_valid && o_tx_ready && rx_cnt < 64) begin
			rx_log[rx_cnt] <= i_tx_code;
			rx_cnt <= rx_cnt + 1;
		end
	end
endmodule

/* tb/tb_abk_answerback.sv */
// Self-checking bench for the answerback message sequencer
`timescale 1ns/100ps
module tb_abk_answerback;
	import abk_pkg::*;
	// ==========================================================
	// Signals
	logic       clk, rst, rx_v, kbd, key, unl, fit, wr, slow, rdy;
	logic [4:0] rx_code, addr, mask, tx_code;
	logic       tx_v, busy, rel, kbd_en, locked, nonc;
	int         fail_count, comparisons;
	abk_remote_model abk_remote_model_i (.i_ref_clk(clk),
		.i_tx_code(tx_code), .i_tx_valid(tx_v), .i_slow(slow),
		.o_tx_ready(rdy));
	abk_answerback abk_answerback_i (.i_ref_clk(clk), .i_reset(rst),
		.i_rx_code(rx_code), .i_rx_valid(rx_v), .i_kbd_cycle(kbd),
		.i_manual_identify_key(key), .i_manual_unlock(unl),
		.i_lock_fitted(fit), .i_msg_wr(wr), .i_msg_addr(addr),
		.i_msg_mask(mask), .o_tx_code(tx_code), .o_tx_valid(tx_v),
		.i_tx_ready(rdy), .o_busy(busy), .o_latch_release(rel),
		.o_kbd_enable(kbd_en), .o_kbd_locked(locked),
		.o_noncontention(nonc));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// Shared tasks
	task results;
		$display("%0d comparisons, %0d mismatches", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task check(input logic [4:0] got, input logic [4:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// Line control characters placed around the identification text
	localparam logic [4:0] TB_CR = 5'h0c;
	localparam logic [4:0] TB_LF = 5'h06;
	function automatic logic [4:0] exp_code(input int p);
		if (p == 0) return ABK_LTRS;
		if (p == 1 || p == 19) return TB_CR;
		if (p == 2 || p == 20) return TB_LF;
		return 5'(p * 7 + 3);
	endfunction
	task rx_char(input logic [4:0] c);
		rx_code = c;
		rx_v = 1'b1;
		@(negedge clk);
		rx_v = 1'b0;
		@(negedge clk);
	endtask
	task wait_busy(input logic v, input int n);
		int k;
		k = 0;
		while (busy !== v && k < n) begin
			@(negedge clk);
			k++;
		end
		if (busy !== v) begin
			fail_count++;
			$display("wrong value at %0t: busy wait timed out", $time);
			results();
		end
	endtask
	task run_check(input int base);
		int k;
		k = 0;
		while (abk_remote_model_i.rx_cnt < base + 21 && k < 600) begin
			@(negedge clk);
			k++;
		end
		if (abk_remote_model_i.rx_cnt < base + 21) begin
			fail_count++;
			$display("wrong value at %0t: character wait timed out", $time);
			results();
		end
		wait_busy(1'b0, 20);
		repeat (20) @(negedge clk);
		check(5'(abk_remote_model_i.rx_cnt - base), 5'h15, "count");
		for (int p = 0; p < 21; p++) begin
			check(abk_remote_model_i.rx_log[base + p], exp_code(p), "code");
		end
		check(tx_v, 1'b0, "cycles not blocked");
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		check({busy, rel, locked, nonc, tx_v}, 5'h00, "reset flags");
		check(kbd_en, 1'b1, "reset kbd");
		$display("test reset done");
	endtask
	task t_config;
		for (int a = 0; a < 22; a++) begin
			addr = 5'(a);
			mask = (a == 0) ? 5'h15 : ~exp_code(a);
			wr = 1'b1;
			@(negedge clk);
		end
		wr = 1'b0;
		$display("test store done");
	endtask
	task t_line(input int base);
		rx_char(ABK_FIGS);
		rx_char(ABK_CHAR_D);
		wait_busy(1'b1, 4);
		check({rel, kbd_en, locked}, 3'h5, "start flags");
		run_check(base);
		check(locked, 1'b1, "lock held");
		unl = 1'b1;
		repeat (4) @(negedge clk);
		unl = 1'b0;
		repeat (6) @(negedge clk);
		check({locked, kbd_en}, 2'h1, "unlock");
		$display("test line trigger done");
	endtask
	task t_nonc;
		kbd = 1'b1;
		rx_char(ABK_FIGS);
		kbd = 1'b0;
		check(nonc, 1'b1, "flag set");
		rx_char(ABK_CHAR_D);
		repeat (6) @(negedge clk);
		check(busy, 1'b0, "own call answered");
		rx_char(ABK_FIGS);
		check(nonc, 1'b0, "flag clear");
		rx_char(5'h0e);
		rx_char(ABK_CHAR_D);
		repeat (6) @(negedge clk);
		check(busy, 1'b0, "broken pair answered");
		$display("test noncontention done");
	endtask
	task t_manual(input int base);
		slow = 1'b1;
		key = 1'b1;
		repeat (6) @(negedge clk);
		key = 1'b0;
		wait_busy(1'b1, 10);
		check(rel, 1'b1, "latch release");
		run_check(base);
		check(locked, 1'b0, "manual locked");
		slow = 1'b0;
		$display("test manual key done");
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		fail_count = 0;
		comparisons = 0;
		{rx_v, kbd, key, unl, wr, slow} = 6'h00;
		{rx_code, addr, mask} = 15'h0000;
		fit = 1'b1;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
		t_config();
		t_line(abk_remote_model_i.rx_cnt);
		t_nonc();
		t_manual(abk_remote_model_i.rx_cnt);
		results();
	end
endmodule
